/* File: verilog/ivc_pkg.sv */
// Constants, types and helpers for the two-wire voltage code control slave
// Operation
// RULE1: Seven-bit level code, reset 0110010, sets output
// RULE2: Master sets bit 7 to XNOR of code
// RULE3: Bad parity: no acknowledge, register kept
// RULE4: Master resends the write after parity nack
// RULE5: Level read returns parity bit with code
// RULE6: Control bit 7 selects internal level source
// RULE7: Writing 0 to bit 7 restores external
// RULE8: Control bit 4 suppresses protection during change
// RULE9: Control bit 3: 0 PFM, 1 PWM
// RULE10: Control bit 0: 0 auto-recovery, 1 latch-off
// RULE11: Bus slave at 100 and 400 kbps
// RULE12: Address match acknowledged on ninth clock
// RULE13: Address mismatch: no acknowledge, wait for START
// RULE14: Direction bit: 0 write, 1 read
// RULE15: Valid data byte acknowledged and stored
// RULE16: Read shifts eight bits, STOP returns idle
// RULE17: Written command applied within 27 SCL periods
// RULE18: Input filter suppresses spikes of 32 ns
// RULE19: Address 6Ch when select low, 6Eh high
// RULE20: Code steps from 0.7 V, bit 5 ignored
// RULE21: Index byte selects register before data
`default_nettype none

package ivc_pkg;

  localparam logic [7:0] IVC_REG_LEVEL = 8'h00;
  localparam logic [7:0] IVC_REG_CTRL  = 8'h01;

  localparam logic [7:0] IVC_ADDR_LO = 8'h6c;
  localparam logic [7:0] IVC_ADDR_HI = 8'h6e;

  localparam logic [7:0] IVC_LEVEL_RST = 8'h32;
  localparam logic [7:0] IVC_CTRL_RST  = 8'h09;
  localparam logic [7:0] IVC_CTRL_MASK = 8'h99;

  localparam int IVC_PAR_BIT   = 7;
  localparam int IVC_CTL_INT   = 7;
  localparam int IVC_CTL_PSUP  = 4;
  localparam int IVC_CTL_LIGHT = 3;
  localparam int IVC_CTL_LATCH = 0;
  localparam int IVC_CODE_SKIP = 5;

  localparam int IVC_MCLK_KHZ = 40000;
  localparam int IVC_TSP_NS   = 32;
  // One extra sample: a spike may straddle a sampling edge
  localparam int IVC_FILT_CYC =
    (IVC_TSP_NS * IVC_MCLK_KHZ + 999999) / 1000000 + 1;
  localparam int IVC_BYTE_BITS = 8;

  typedef enum logic [3:0] {
    IVC_IDLE,
    IVC_ADDR,
    IVC_ADDR_ACK,
    IVC_INDEX,
    IVC_INDEX_ACK,
    IVC_DATA,
    IVC_DATA_ACK,
    IVC_READ,
    IVC_READ_ACK,
    IVC_IGNORE
  } ivc_state_t;

  function automatic logic ivc_odd_ok(input logic [7:0] b);
    ivc_odd_ok = (b[IVC_PAR_BIT] == ~^b[6:0]);
  endfunction

endpackage

`default_nettype wire

/* File: verilog/ivc_slave.sv */
// Two-wire bus slave holding the level code and regulator control registers
`default_nettype none

module ivc_slave
  import ivc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       address_select_pin,
  output logic [6:0]      output_level_code,
  output logic [5:0]      level_step,
  output logic            level_update,
  output logic            internal_mode,
  output logic            protect_suppress,
  output logic            light_load_select,
  output logic            latch_off
);

  typedef struct packed {
    ivc_state_t st;
    logic [7:0] sr;
    logic [3:0] cnt;
    logic       oe;
    logic       rd;
    logic       idx;
    logic [7:0] level;
    logic [5:0] step;
    logic       lvl_chg;
    logic [7:0] ctrl;
    logic       scl_s1;
    logic       scl_s2;
    logic       sda_s1;
    logic       sda_s2;
    logic       asel_s1;
    logic       asel_s2;
    logic       scl_f;
    logic       sda_f;
    logic [3:0] scl_c;
    logic [3:0] sda_c;
    logic       scl_p;
    logic       sda_p;
  } ivc_regs_t;

  ivc_regs_t q;
  ivc_regs_t d;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       byte_end;
  logic       par_ok;
  logic [7:0] my_addr;
  logic [7:0] rd_byte;

  // Filter: the line follows its input only after it has held the
  // new level for the whole filter window
  function automatic logic [4:0] ivc_filt(input logic       s,
                                          input logic       f,
                                          input logic [3:0] c);
    logic [4:0] r;
    r = {f, 4'h0};
    if (s != f) begin
      if (c == 4'(IVC_FILT_CYC - 1)) begin
        r = {s, 4'h0};
      end else begin
        r = {f, c + 4'h1};
      end
    end
    ivc_filt = r;
  endfunction

  assign scl_rise  = q.scl_f & ~q.scl_p;
  assign scl_fall  = ~q.scl_f & q.scl_p;
  assign start_det = q.scl_f & q.scl_p & q.sda_p & ~q.sda_f;
  assign stop_det  = q.scl_f & q.scl_p & ~q.sda_p & q.sda_f;
  assign byte_end  = scl_fall & (q.cnt == 4'(IVC_BYTE_BITS));
  assign par_ok    = ivc_odd_ok(q.sr); // [RULE2] [RULE3]
  assign my_addr   = q.asel_s2 ? IVC_ADDR_HI : IVC_ADDR_LO; // [RULE19]
  assign rd_byte   = q.idx ? q.ctrl : q.level; // [RULE5] [RULE21]

  always_comb begin
    d = q;
    d.lvl_chg = 1'b0;
    d.scl_s1  = scl_in;
    d.scl_s2  = q.scl_s1;
    d.sda_s1  = sda_in;
    d.sda_s2  = q.sda_s1;
    d.asel_s1 = address_select_pin;
    d.asel_s2 = q.asel_s1;
    // Short window keeps 400 kbps margins while removing glitches
    {d.scl_f, d.scl_c} = ivc_filt(q.scl_s2, q.scl_f, q.scl_c); // [RULE18]
    {d.sda_f, d.sda_c} = ivc_filt(q.sda_s2, q.sda_f, q.sda_c); // [RULE18]
    d.scl_p = q.scl_f;
    d.sda_p = q.sda_f;

    case (q.st)
      IVC_ADDR, IVC_INDEX, IVC_DATA: begin
        if (scl_rise && q.cnt < 4'(IVC_BYTE_BITS)) begin
          d.sr  = {q.sr[6:0], q.sda_f};
          d.cnt = q.cnt + 4'h1;
        end
        if (byte_end) begin
          d.cnt = 4'h0;
          d.st  = IVC_IGNORE;
          if (q.st == IVC_ADDR) begin
            if (q.sr[7:1] == my_addr[7:1]) begin // [RULE12] [RULE13]
              d.oe = 1'b1;
              d.rd = q.sr[0]; // [RULE14]
              d.st = IVC_ADDR_ACK;
            end
          end else if (q.st == IVC_INDEX) begin
            if (q.sr[7:1] == IVC_REG_LEVEL[7:1]) begin // [RULE21]
              d.idx = q.sr[0];
              d.oe  = 1'b1;
              d.st  = IVC_INDEX_ACK;
            end
          end else if (par_ok) begin // [RULE3] [RULE15]
            d.oe = 1'b1;
            d.st = IVC_DATA_ACK;
            // Applied at the eighth data bit, well inside the limit
            if (q.idx) begin // [RULE17]
              d.ctrl = q.sr & IVC_CTRL_MASK; // [RULE6] [RULE7]
            end else begin
              d.level   = q.sr; // [RULE1]
              d.step    = {q.sr[6], q.sr[4:0]}; // [RULE20]
              d.lvl_chg = 1'b1;
            end
          end
        end
      end
      IVC_ADDR_ACK: begin
        if (scl_fall) begin
          d.cnt = 4'h0;
          if (q.rd) begin
            d.sr = rd_byte;
            d.oe = ~rd_byte[7]; // [RULE16]
            d.st = IVC_READ;
          end else begin
            d.oe = 1'b0;
            d.st = IVC_INDEX;
          end
        end
      end
      IVC_INDEX_ACK, IVC_DATA_ACK: begin
        if (scl_fall) begin
          d.oe  = 1'b0;
          d.cnt = 4'h0;
          d.st  = IVC_DATA;
        end
      end
      IVC_READ: begin
        if (scl_rise) begin
          d.cnt = q.cnt + 4'h1;
        end
        if (byte_end) begin
          d.oe = 1'b0; // [RULE16]
          d.st = IVC_READ_ACK;
        end else if (scl_fall) begin
          d.sr = {q.sr[6:0], 1'b0};
          d.oe = ~q.sr[6];
        end
      end
      IVC_READ_ACK: begin
        // The master's answer is not needed: the ninth SCL fall ends the read, then IGNORE waits for STOP or START
        if (scl_fall) begin
          d.st = IVC_IGNORE; // [RULE16]
        end
      end
      IVC_IDLE, IVC_IGNORE: begin
        d.oe = 1'b0; // [RULE13]
      end
      default: begin
        d.st = IVC_IDLE;
        d.oe = 1'b0;
      end
    endcase

    if (start_det) begin // [RULE12]
      d.st  = IVC_ADDR;
      d.cnt = 4'h0;
      d.oe  = 1'b0;
    end else if (stop_det) begin // [RULE16]
      d.st  = IVC_IDLE;
      d.cnt = 4'h0;
      d.oe  = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q         <= '0;
      q.st      <= IVC_IDLE;
      q.level   <= IVC_LEVEL_RST; // [RULE1]
      q.step    <= {IVC_LEVEL_RST[6], IVC_LEVEL_RST[4:0]};
      q.ctrl    <= IVC_CTRL_RST; // [RULE6] [RULE8] [RULE9] [RULE10]
      q.scl_s1  <= 1'b1;
      q.scl_s2  <= 1'b1;
      q.sda_s1  <= 1'b1;
      q.sda_s2  <= 1'b1;
      q.scl_f   <= 1'b1;
      q.sda_f   <= 1'b1;
      q.scl_p   <= 1'b1;
      q.sda_p   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_out           = 1'b0;
  assign sda_oe            = q.oe; // [RULE11]
  assign output_level_code = q.level[6:0];
  assign level_step        = q.step;
  assign level_update      = q.lvl_chg;
  assign internal_mode     = q.ctrl[IVC_CTL_INT]; // [RULE6]
  assign protect_suppress  = q.ctrl[IVC_CTL_PSUP]; // [RULE8]
  assign light_load_select = q.ctrl[IVC_CTL_LIGHT]; // [RULE9]
  assign latch_off         = q.ctrl[IVC_CTL_LATCH]; // [RULE10]

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  chk_bad_parity_keep: // [RULE3]
    assert property (q.st == IVC_DATA && byte_end && !par_ok
                     |=> $stable(q.level) && $stable(q.ctrl) && !q.oe)
    else $error("bad parity byte changed a register or was acked");

  chk_good_commit: // [RULE15]
    assert property (q.st == IVC_DATA && byte_end && par_ok && !q.idx
                     |=> q.level == $past(q.sr) && q.oe && q.lvl_chg)
    else $error("valid level byte not stored and acked");

  chk_addr_ack: // [RULE12]
    assert property (q.st == IVC_ADDR && byte_end && !start_det
                     && q.sr[7:1] == my_addr[7:1]
                     |=> q.oe && q.st == IVC_ADDR_ACK)
    else $error("matching address not acknowledged");

  chk_ignore_quiet: // [RULE13]
    assert property (q.st == IVC_IGNORE || q.st == IVC_IDLE |-> !q.oe)
    else $error("bus driven while not addressed");

  chk_ext_mode: // [RULE7]
    assert property (q.st == IVC_DATA && byte_end && par_ok && q.idx
                     && !q.sr[IVC_CTL_INT] && !start_det
                     |=> !internal_mode ##1 !internal_mode)
    else $error("writing zero did not restore external mode");

  chk_stop_idle: // [RULE16]
    assert property (stop_det |=> q.st == IVC_IDLE && !sda_oe)
    else $error("stop did not return slave to idle");

  chk_filter_spike: // [RULE18]
    assert property ($changed(q.scl_f)
                     |-> $past(q.scl_s2, 1) == q.scl_f
                     && $past(q.scl_s2, 2) == q.scl_f
                     && $past(q.scl_s2, 3) == q.scl_f)
    else $error("clock filter passed a short spike");

  chk_dir_read: // [RULE14]
    assert property (q.st == IVC_ADDR_ACK && scl_fall && q.rd && !stop_det
                     && !start_det |=> q.st == IVC_READ
                     && q.oe == ~$past(rd_byte[7]))
    else $error("read direction did not start shifting out");

  chk_write_dir: // [RULE14]
    assert property (q.st == IVC_ADDR_ACK && scl_fall && !q.rd
                     |=> q.st == IVC_INDEX && !q.oe)
    else $error("write direction did not move to index byte");

  chk_addr_nack: // [RULE13]
    assert property (q.st == IVC_ADDR && byte_end
                     && q.sr[7:1] != my_addr[7:1]
                     |=> q.st == IVC_IGNORE && !q.oe)
    else $error("foreign address was acknowledged");

  chk_start_addr: // [RULE12]
    assert property (start_det
                     |=> q.st == IVC_ADDR && q.cnt == 4'h0 && !q.oe)
    else $error("start did not restart address reception");

  chk_index_ack: // [RULE21]
    assert property (q.st == IVC_INDEX && byte_end
                     && q.sr[7:1] == IVC_REG_LEVEL[7:1]
                     |=> q.oe && q.st == IVC_INDEX_ACK
                     && q.idx == $past(q.sr[0]))
    else $error("valid register index not taken");

  chk_index_refuse: // [RULE21]
    assert property (q.st == IVC_INDEX && byte_end
                     && q.sr[7:1] != IVC_REG_LEVEL[7:1]
                     |=> q.st == IVC_IGNORE && !q.oe)
    else $error("unknown register index was acknowledged");

  chk_ctrl_commit: // [RULE6]
    assert property (q.st == IVC_DATA && byte_end && par_ok && q.idx
                     |=> q.ctrl == ($past(q.sr) & IVC_CTRL_MASK)
                     && $stable(q.level) && q.oe && !q.lvl_chg)
    else $error("valid control byte not stored and acked");

  // Registers may only move at the end of a data byte
  chk_reg_hold: // [RULE1]
    assert property (!(q.st == IVC_DATA && byte_end)
                     |=> $stable(q.level) && $stable(q.ctrl))
    else $error("register changed outside a data byte");

  chk_ack_release: // [RULE12]
    assert property ((q.st == IVC_INDEX_ACK || q.st == IVC_DATA_ACK)
                     && scl_fall |=> !q.oe && q.st == IVC_DATA)
    else $error("acknowledge held past the ninth clock");

  chk_update_pulse: // [RULE17]
    assert property (level_update
                     |-> q.st == IVC_DATA_ACK && !q.idx && q.oe)
    else $error("level update outside an accepted level byte");

  chk_read_shift: // [RULE16]
    assert property (q.st == IVC_READ && scl_fall && !byte_end
                     |=> q.oe == ~$past(q.sr[6]))
    else $error("read data bit not shifted out");

  chk_read_release: // [RULE16]
    assert property (q.st == IVC_READ && byte_end
                     |=> q.st == IVC_READ_ACK && !q.oe)
    else $error("data line held after eighth read bit");

  chk_read_ack_end: // [RULE16]
    assert property (q.st == IVC_READ_ACK && scl_fall
                     |=> q.st == IVC_IGNORE && !q.oe)
    else $error("read did not wait for stop after ack bit");

  chk_sda_filter: // [RULE18]
    assert property ($changed(q.sda_f)
                     |-> $past(q.sda_s2, 1) == q.sda_f
                     && $past(q.sda_s2, 2) == q.sda_f
                     && $past(q.sda_s2, 3) == q.sda_f)
    else $error("data filter passed a short spike");

  chk_ctrl_reserved: // [RULE6]
    assert property ((q.ctrl & ~IVC_CTRL_MASK) == 8'h00)
    else $error("unused control bit set");

  chk_level_step: // [RULE20]
    assert property (level_step == {output_level_code[6],
                                    output_level_code[4:0]})
    else $error("level step does not skip code bit five");

endmodule

`default_nettype wire

/* File: tb/ivc_master.sv */
// Two-wire bus master model: drives SCL, pulls SDA low
`default_nettype none
module ivc_master (
  input  wire logic mclk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter of a 400 ns bus period: the slave moves SDA about six system
  // clocks after each SCL fall, so a shorter low phase would let its
  // release overlap the next high phase; SCL stands still between frames
  task automatic q();
    repeat (4) @(negedge mclk);
  endtask
  task automatic start();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
  endtask
  task automatic stop();
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    repeat (8) q();
  endtask
  // Sample late in the high phase: slave answers after its filter delay
  task automatic bit_x(input logic b, input logic gl, output logic s);
    if (gl) begin
      #5 scl = 1'b1;
      #30 scl = 1'b0;
    end
    q();
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    q();
    s = sda;
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, input logic gl,
                       output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], gl, s);
    bit_x(1'b1, 1'b0, s);
    ack = ~s;
  endtask
  task automatic rbyte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, 1'b0, s);
      d[i] = s;
    end
    bit_x(1'b1, 1'b0, s);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the level code and control slave
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  error_cnt++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ivc_pkg::*;
  logic       mclk, rst_b, scl, sda_low, sel, sda_oe, sda_out, upd;
  logic       im, ps, ll, lo;
  logic [6:0] code;
  logic [5:0] step;
  logic [7:0] m_lvl, m_ctl, d, x, adr;
  logic [2:0] a;
  logic       ok;
  wire        sda = ~(sda_low | (sda_oe & ~sda_out));
  int         error_cnt, total_checks, m_upd, upd_cnt;
  ivc_slave dut_u (.mclk(mclk), .rst_b(rst_b), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pin(sel), .output_level_code(code),
    .level_step(step), .level_update(upd), .internal_mode(im),
    .protect_suppress(ps), .light_load_select(ll), .latch_off(lo));
  ivc_master mst_u (.mclk(mclk), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(negedge mclk) if (upd === 1'b1) upd_cnt++;
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, ix, dv, input logic gl);
    mst_u.start();
    mst_u.wbyte(ad, gl, a[2]);
    mst_u.wbyte(ix, 1'b0, a[1]);
    mst_u.wbyte(dv, 1'b0, a[0]);
    mst_u.stop();
  endtask
  task automatic rd(input logic [7:0] ix);
    mst_u.start();
    mst_u.wbyte(adr, 1'b0, a[2]);
    mst_u.wbyte(ix, 1'b0, a[1]);
    mst_u.stop();
    mst_u.start();
    mst_u.wbyte(adr | 8'h01, 1'b0, a[0]);
    mst_u.rbyte(x);
    mst_u.stop();
    `CHK(a, 3'b111)
  endtask
  task automatic cmp_out();
    `CHK(code, m_lvl[6:0])
    `CHK(step, {m_lvl[6], m_lvl[4:0]})
    `CHK(im, m_ctl[7])
    `CHK(ps, m_ctl[4])
    `CHK(ll, m_ctl[3])
    `CHK(lo, m_ctl[0])
    `CHK(upd_cnt, m_upd)
  endtask
  // Random 7-bit code; bad flips the parity bit
  task automatic mk(input logic bad);
    d[6:0] = 7'($urandom);
    d[7] = ~^d[6:0] ^ bad;
    ok = ~bad;
  endtask
  initial begin
    rst_b = 1'b0;
    sel = 1'b0;
    adr = 8'h6c;
    m_lvl = 8'h32;
    m_ctl = 8'h09;
    void'($urandom(32'hdb6d402e));
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    repeat (10) @(negedge mclk);
    cmp_out();
    for (int i = 0; i < 14; i++) begin
      mk(i % 3 == 0);
      wr(adr, 8'(i / 8), d, i == 5);
      `CHK(a, {2'b11, ok})
      if (!ok) begin
        d[7] = ~d[7];
        wr(adr, 8'(i / 8), d, 1'b0);
        `CHK(a, 3'b111)
      end
      if (i < 8) m_lvl = d;
      if (i < 8) m_upd++;
      else m_ctl = d & IVC_CTRL_MASK;
      cmp_out();
      rd(8'(i / 8));
      `CHK(x, (i < 8) ? m_lvl : m_ctl)
    end
    // A wrong address is ignored for both settings of the select pin
    for (int s = 0; s < 2; s++) begin
      sel = 1'(s);
      adr = s ? 8'h6e : 8'h6c;
      repeat (4) @(negedge mclk);
      mk(1'b0);
      wr(adr ^ 8'h02, 8'h00, d, 1'b0);
      `CHK(a, 3'b000)
      wr(adr, 8'h02, d, 1'b0);
      `CHK(a, 3'b100)
      cmp_out();
      wr(adr, 8'h00, d, 1'b0);
      `CHK(a, 3'b111)
      m_lvl = d;
      m_upd++;
      cmp_out();
    end
    wrap_up();
  end
  initial begin
    repeat (80000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
